// >>> hw/reset_bank_consts.svh
// Register offsets, field positions, masks and reset values of the peripheral soft reset bank.
`ifndef RESET_BANK_CONSTS_SVH
`define RESET_BANK_CONSTS_SVH

`define ADDR_W               12
`define OFS_FAST_RST         12'h00c
`define OFS_SLOW_RST         12'h010
`define OFS_CLK_EN           12'h014
`define OFS_RSVD_STATUS      12'h040

`define RESET_FAST_RST       32'h0000_0000
`define RESET_SLOW_RST       32'h0000_0000
`define RESET_CLK_EN         32'h0000_0014
`define ZERO_WORD            32'h0000_0000

`define MASK_FAST_RST        32'h0007_5a01
`define MASK_SLOW_RST        32'h7062_4913
`define MASK_CLK_EN          32'h015e_1055

`define BIT_GP_TIMER_SIXTEEN 18
`define BIT_GP_TIMER_FIFTEEN 17
`define BIT_GP_TIMER_FOURTEEN 16
`define BIT_SERIAL_XCVR_A    14
`define BIT_SERIAL_PIF_A     12
`define BIT_ADV_TIMER_ZERO   11
`define BIT_ADC_UNIT         9
`define BIT_SYSCFG_CMP       0

`define BIT_CONSUMER_CTRL    30
`define BIT_DAC_UNIT         29
`define BIT_POWER_CTRL       28
`define BIT_TWO_WIRE_B       22
`define BIT_TWO_WIRE_A       21
`define BIT_SERIAL_XCVR_B    17
`define BIT_SERIAL_PIF_B     14
`define BIT_WINDOW_WATCHDOG  11
`define BIT_BASIC_TIMER_13   8
`define BIT_BASIC_TIMER_5    4
`define BIT_GP_TIMER_TWO     1
`define BIT_GP_TIMER_ONE     0

`define STAT_BIT_FAST        0
`define STAT_BIT_SLOW        1
`define STAT_BIT_CLK         2

`endif

// >>> hw/reset_bank_pkg.sv
// Types shared by the peripheral soft reset bank.
`default_nettype none
package reset_bank_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;

endpackage
`default_nettype wire

// >>> hw/masked_word_reg.sv
// One software register with a writable-bit mask and byte-lane writes.
`default_nettype none
module masked_word_reg
  import reset_bank_pkg::*;
#(
  parameter word_t RESET_VALUE = 32'h0000_0000,
  parameter word_t WRITE_MASK  = 32'hffff_ffff
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         write_en,
  input  wire logic [31:0]  wdata,
  input  wire logic [31:0]  lane_mask,
  output logic      [31:0]  value_q
);

  logic [31:0] take;

  // Bits outside the mask never change, so reserved positions keep their reset value.
  assign take = WRITE_MASK & lane_mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_q <= RESET_VALUE;
    end
    else if (write_en)
    begin
      value_q <= (value_q & ~take) | (wdata & take);
    end
  end

endmodule
`default_nettype wire

// >>> hw/sticky_flag.sv
// Sticky status bit set by hardware and cleared by software, where a set wins over a clear.
`default_nettype none
module sticky_flag
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag_q
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= 1'b0;
    end
    else if (set_pulse)
    begin
      flag_q <= 1'b1;
    end
    else if (clear_pulse)
    begin
      flag_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> hw/peripheral_soft_reset_bank.sv
// APB register bank that holds the per-peripheral soft reset lines and the system bus clock enables.
`include "reset_bank_consts.svh"
`default_nettype none
module peripheral_soft_reset_bank
  import reset_bank_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     gp_timer_sixteen_reset,
  output logic                     gp_timer_fifteen_reset,
  output logic                     gp_timer_fourteen_reset,
  output logic                     serial_xcvr_a_reset,
  output logic                     serial_periph_if_a_reset,
  output logic                     advanced_timer_zero_reset,
  output logic                     adc_unit_reset,
  output logic                     sysconfig_comparator_reset,
  output logic                     consumer_ctrl_reset,
  output logic                     dac_unit_reset,
  output logic                     power_ctrl_reset,
  output logic                     two_wire_b_reset,
  output logic                     two_wire_a_reset,
  output logic                     serial_xcvr_b_reset,
  output logic                     serial_periph_if_b_reset,
  output logic                     window_watchdog_reset,
  output logic                     basic_timer_thirteen_reset,
  output logic                     basic_timer_five_reset,
  output logic                     gp_timer_two_reset,
  output logic                     gp_timer_one_reset,
  output logic      [31:0]         system_bus_clock_enable
);

  import reset_bank_pkg::*;

  apb_state_t        state_q;
  apb_state_t        state_d;
  logic              hit_fast;
  logic              hit_slow;
  logic              hit_clk;
  logic              hit_stat;
  logic              addr_ok;
  logic              sel_fast_q;
  logic              sel_slow_q;
  logic              sel_clk_q;
  logic              sel_stat_q;
  logic              err_q;
  logic              setup_phase;
  logic              access_done;
  logic              write_commit;
  logic [31:0]       lane_mask;
  logic [31:0]       read_word;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  word_t             fast_rst_q;
  word_t             slow_rst_q;
  word_t             clk_en_q;
  logic              rsvd_fast_q;
  logic              rsvd_slow_q;
  logic              rsvd_clk_q;
  logic              set_rsvd_fast;
  logic              set_rsvd_slow;
  logic              set_rsvd_clk;
  logic              clr_rsvd_fast;
  logic              clr_rsvd_slow;
  logic              clr_rsvd_clk;
  logic [31:0]       status_word;

  // Address decode for the setup cycle; only word-aligned addresses are mapped.
  assign addr_ok  = (paddr[1:0] == 2'h0);
  assign hit_fast = addr_ok && (paddr == `OFS_FAST_RST);
  assign hit_slow = addr_ok && (paddr == `OFS_SLOW_RST);
  assign hit_clk  = addr_ok && (paddr == `OFS_CLK_EN);
  assign hit_stat = addr_ok && (paddr == `OFS_RSVD_STATUS);

  assign setup_phase = psel && !penable && (state_q == ST_IDLE);
  assign access_done = psel && penable && pready_q && (state_q == ST_ACCESS);

  // An erroring transfer must leave every register untouched.
  assign write_commit = access_done && pwrite && !err_q;

  always_comb
  begin
    lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (setup_phase)
        begin
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS:
      begin
        if (access_done || !psel)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // The decode is latched in setup so the access phase does not depend on a late address.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_fast_q <= 1'b0;
      sel_slow_q <= 1'b0;
      sel_clk_q  <= 1'b0;
      sel_stat_q <= 1'b0;
      err_q      <= 1'b0;
    end
    else if (setup_phase)
    begin
      sel_fast_q <= hit_fast;
      sel_slow_q <= hit_slow;
      sel_clk_q  <= hit_clk;
      sel_stat_q <= hit_stat;
      err_q      <= !(hit_fast || hit_slow || hit_clk || hit_stat);
    end
  end

  assign status_word = {29'h0000_0000, rsvd_clk_q, rsvd_slow_q, rsvd_fast_q};

  always_comb
  begin
    read_word = `ZERO_WORD;
    if (hit_fast)
    begin
      read_word = fast_rst_q;
    end
    else if (hit_slow)
    begin
      read_word = slow_rst_q;
    end
    else if (hit_clk)
    begin
      read_word = clk_en_q;
    end
    else if (hit_stat)
    begin
      read_word = status_word;
    end
  end

  // Zero wait states: pready rises in the first access cycle. Read data is captured in setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `ZERO_WORD;
    end
    else if (setup_phase)
    begin
      pready_q  <= 1'b1;
      pslverr_q <= !(hit_fast || hit_slow || hit_clk || hit_stat);
      prdata_q  <= pwrite ? `ZERO_WORD : read_word;
    end
    else if (access_done || !psel)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `ZERO_WORD;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  masked_word_reg #(
    .RESET_VALUE (`RESET_FAST_RST),
    .WRITE_MASK  (`MASK_FAST_RST)
  ) u_fast_rst (
    .pclk      (pclk),
    .presetn   (presetn),
    .write_en  (write_commit && sel_fast_q),
    .wdata     (pwdata),
    .lane_mask (lane_mask),
    .value_q   (fast_rst_q)
  );

  masked_word_reg #(
    .RESET_VALUE (`RESET_SLOW_RST),
    .WRITE_MASK  (`MASK_SLOW_RST)
  ) u_slow_rst (
    .pclk      (pclk),
    .presetn   (presetn),
    .write_en  (write_commit && sel_slow_q),
    .wdata     (pwdata),
    .lane_mask (lane_mask),
    .value_q   (slow_rst_q)
  );

  masked_word_reg #(
    .RESET_VALUE (`RESET_CLK_EN),
    .WRITE_MASK  (`MASK_CLK_EN)
  ) u_clk_en (
    .pclk      (pclk),
    .presetn   (presetn),
    .write_en  (write_commit && sel_clk_q),
    .wdata     (pwdata),
    .lane_mask (lane_mask),
    .value_q   (clk_en_q)
  );

  // Ones written to reserved positions are dropped; a sticky flag records the misuse for software.
  assign set_rsvd_fast = write_commit && sel_fast_q && |(pwdata & lane_mask & ~`MASK_FAST_RST);
  assign set_rsvd_slow = write_commit && sel_slow_q && |(pwdata & lane_mask & ~`MASK_SLOW_RST);
  assign set_rsvd_clk  = write_commit && sel_clk_q && |(pwdata & lane_mask & ~`MASK_CLK_EN);

  assign clr_rsvd_fast = write_commit && sel_stat_q && pstrb[0] && pwdata[`STAT_BIT_FAST];
  assign clr_rsvd_slow = write_commit && sel_stat_q && pstrb[0] && pwdata[`STAT_BIT_SLOW];
  assign clr_rsvd_clk  = write_commit && sel_stat_q && pstrb[0] && pwdata[`STAT_BIT_CLK];

  sticky_flag u_rsvd_fast (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_pulse   (set_rsvd_fast),
    .clear_pulse (clr_rsvd_fast),
    .flag_q      (rsvd_fast_q)
  );

  sticky_flag u_rsvd_slow (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_pulse   (set_rsvd_slow),
    .clear_pulse (clr_rsvd_slow),
    .flag_q      (rsvd_slow_q)
  );

  sticky_flag u_rsvd_clk (
    .pclk        (pclk),
    .presetn     (presetn),
    .set_pulse   (set_rsvd_clk),
    .clear_pulse (clr_rsvd_clk),
    .flag_q      (rsvd_clk_q)
  );

  // Reset lines are the register flops themselves, so a peripheral is held for as long as its bit is one.
  assign gp_timer_sixteen_reset     = fast_rst_q[`BIT_GP_TIMER_SIXTEEN];
  assign gp_timer_fifteen_reset     = fast_rst_q[`BIT_GP_TIMER_FIFTEEN];
  assign gp_timer_fourteen_reset    = fast_rst_q[`BIT_GP_TIMER_FOURTEEN];
  assign serial_xcvr_a_reset        = fast_rst_q[`BIT_SERIAL_XCVR_A];
  assign serial_periph_if_a_reset   = fast_rst_q[`BIT_SERIAL_PIF_A];
  assign advanced_timer_zero_reset  = fast_rst_q[`BIT_ADV_TIMER_ZERO];
  assign adc_unit_reset             = fast_rst_q[`BIT_ADC_UNIT];
  assign sysconfig_comparator_reset = fast_rst_q[`BIT_SYSCFG_CMP];

  assign consumer_ctrl_reset        = slow_rst_q[`BIT_CONSUMER_CTRL];
  assign dac_unit_reset             = slow_rst_q[`BIT_DAC_UNIT];
  assign power_ctrl_reset           = slow_rst_q[`BIT_POWER_CTRL];
  assign two_wire_b_reset           = slow_rst_q[`BIT_TWO_WIRE_B];
  assign two_wire_a_reset           = slow_rst_q[`BIT_TWO_WIRE_A];
  assign serial_xcvr_b_reset        = slow_rst_q[`BIT_SERIAL_XCVR_B];
  assign serial_periph_if_b_reset   = slow_rst_q[`BIT_SERIAL_PIF_B];
  assign window_watchdog_reset      = slow_rst_q[`BIT_WINDOW_WATCHDOG];
  assign basic_timer_thirteen_reset = slow_rst_q[`BIT_BASIC_TIMER_13];
  assign basic_timer_five_reset     = slow_rst_q[`BIT_BASIC_TIMER_5];
  assign gp_timer_two_reset         = slow_rst_q[`BIT_GP_TIMER_TWO];
  assign gp_timer_one_reset         = slow_rst_q[`BIT_GP_TIMER_ONE];

  assign system_bus_clock_enable    = clk_en_q;

endmodule
`default_nettype wire

// >>> sim/peripheral_soft_reset_bank_monitor.sv
// Checker of bus timing, register contents and reset lines of the peripheral soft reset bank.
`include "reset_bank_consts.svh"
`default_nettype none
module peripheral_soft_reset_bank_monitor
  import reset_bank_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        gp_timer_sixteen_reset,
  input wire logic        gp_timer_fifteen_reset,
  input wire logic        gp_timer_fourteen_reset,
  input wire logic        serial_xcvr_a_reset,
  input wire logic        serial_periph_if_a_reset,
  input wire logic        advanced_timer_zero_reset,
  input wire logic        adc_unit_reset,
  input wire logic        sysconfig_comparator_reset,
  input wire logic        consumer_ctrl_reset,
  input wire logic        dac_unit_reset,
  input wire logic        power_ctrl_reset,
  input wire logic        two_wire_b_reset,
  input wire logic        two_wire_a_reset,
  input wire logic        serial_xcvr_b_reset,
  input wire logic        serial_periph_if_b_reset,
  input wire logic        window_watchdog_reset,
  input wire logic        basic_timer_thirteen_reset,
  input wire logic        basic_timer_five_reset,
  input wire logic        gp_timer_two_reset,
  input wire logic        gp_timer_one_reset,
  input wire logic [31:0] system_bus_clock_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic        done = psel && penable && pready;
  wire logic [31:0] fast_v = {13'h0, gp_timer_sixteen_reset, gp_timer_fifteen_reset, gp_timer_fourteen_reset,
    1'b0, serial_xcvr_a_reset, 1'b0, serial_periph_if_a_reset, advanced_timer_zero_reset, 1'b0, adc_unit_reset,
    8'h0, sysconfig_comparator_reset};
  wire logic [31:0] slow_v = {1'b0, consumer_ctrl_reset, dac_unit_reset, power_ctrl_reset, 5'h0, two_wire_b_reset,
    two_wire_a_reset, 3'h0, serial_xcvr_b_reset, 2'h0, serial_periph_if_b_reset, 2'h0, window_watchdog_reset, 2'h0,
    basic_timer_thirteen_reset, 3'h0, basic_timer_five_reset, 2'h0, gp_timer_two_reset, gp_timer_one_reset};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
    else $error("no ready one cycle after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_unmapped_error: assert property (done && !(paddr inside {`OFS_FAST_RST, `OFS_SLOW_RST, `OFS_CLK_EN,
    `OFS_RSVD_STATUS}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_fast_write: assert property (done && pwrite && paddr == `OFS_FAST_RST && pstrb == 4'hf
    |=> fast_v == ($past(pwdata) & `MASK_FAST_RST))
    else $error("fast reset lines wrong after write");
  chk_slow_write: assert property (done && pwrite && paddr == `OFS_SLOW_RST && pstrb == 4'hf
    |=> slow_v == ($past(pwdata) & `MASK_SLOW_RST))
    else $error("slow reset lines wrong after write");
  chk_clk_write: assert property (done && pwrite && paddr == `OFS_CLK_EN && pstrb == 4'hf
    |=> system_bus_clock_enable == ($past(pwdata) & `MASK_CLK_EN))
    else $error("clock enable wrong after write");
  chk_lines_hold: assert property (!$past(done && pwrite)
    |-> $stable(fast_v) && $stable(slow_v) && $stable(system_bus_clock_enable))
    else $error("outputs changed without a write");
  chk_fast_read: assert property (done && !pwrite && paddr == `OFS_FAST_RST |-> prdata == fast_v)
    else $error("fast register read mismatch");
  chk_slow_read: assert property (done && !pwrite && paddr == `OFS_SLOW_RST |-> prdata == slow_v)
    else $error("slow register read mismatch");
endmodule

bind peripheral_soft_reset_bank peripheral_soft_reset_bank_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .gp_timer_sixteen_reset, .gp_timer_fifteen_reset,
  .gp_timer_fourteen_reset, .serial_xcvr_a_reset, .serial_periph_if_a_reset, .advanced_timer_zero_reset,
  .adc_unit_reset, .sysconfig_comparator_reset, .consumer_ctrl_reset, .dac_unit_reset, .power_ctrl_reset,
  .two_wire_b_reset, .two_wire_a_reset, .serial_xcvr_b_reset, .serial_periph_if_b_reset, .window_watchdog_reset,
  .basic_timer_thirteen_reset, .basic_timer_five_reset, .gp_timer_two_reset, .gp_timer_one_reset,
  .system_bus_clock_enable);
`default_nettype wire

// >>> sim/peripheral_soft_reset_bank_tb.sv
// Self-checking bench of the peripheral soft reset bank.
`include "reset_bank_consts.svh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module peripheral_soft_reset_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import reset_bank_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, system_bus_clock_enable;
  logic [3:0] pstrb;
  logic gp_timer_sixteen_reset, gp_timer_fifteen_reset, gp_timer_fourteen_reset, serial_xcvr_a_reset;
  logic serial_periph_if_a_reset, advanced_timer_zero_reset, adc_unit_reset, sysconfig_comparator_reset;
  logic consumer_ctrl_reset, dac_unit_reset, power_ctrl_reset, two_wire_b_reset, two_wire_a_reset;
  logic serial_xcvr_b_reset, serial_periph_if_b_reset, window_watchdog_reset, basic_timer_thirteen_reset;
  logic basic_timer_five_reset, gp_timer_two_reset, gp_timer_one_reset;
  int n_errors, comparisons;
  logic [15:0] lfsr_q;
  word_t m [3];
  word_t r, d, x;
  logic e;
  int idx;
  word_t mk [3] = '{`MASK_FAST_RST, `MASK_SLOW_RST, `MASK_CLK_EN};
  logic [11:0] adr [5] = '{`OFS_FAST_RST, `OFS_SLOW_RST, `OFS_CLK_EN, 12'h020, 12'h00d};
  wire logic [31:0] fast_o = {13'h0, gp_timer_sixteen_reset, gp_timer_fifteen_reset, gp_timer_fourteen_reset,
    1'b0, serial_xcvr_a_reset, 1'b0, serial_periph_if_a_reset, advanced_timer_zero_reset, 1'b0, adc_unit_reset,
    8'h0, sysconfig_comparator_reset};
  wire logic [31:0] slow_o = {1'b0, consumer_ctrl_reset, dac_unit_reset, power_ctrl_reset, 5'h0, two_wire_b_reset,
    two_wire_a_reset, 3'h0, serial_xcvr_b_reset, 2'h0, serial_periph_if_b_reset, 2'h0, window_watchdog_reset, 2'h0,
    basic_timer_thirteen_reset, 3'h0, basic_timer_five_reset, 2'h0, gp_timer_two_reset, gp_timer_one_reset};

  peripheral_soft_reset_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .gp_timer_sixteen_reset, .gp_timer_fifteen_reset, .gp_timer_fourteen_reset,
    .serial_xcvr_a_reset, .serial_periph_if_a_reset, .advanced_timer_zero_reset, .adc_unit_reset,
    .sysconfig_comparator_reset, .consumer_ctrl_reset, .dac_unit_reset, .power_ctrl_reset, .two_wire_b_reset,
    .two_wire_a_reset, .serial_xcvr_b_reset, .serial_periph_if_b_reset, .window_watchdog_reset,
    .basic_timer_thirteen_reset, .basic_timer_five_reset, .gp_timer_two_reset, .gp_timer_one_reset,
    .system_bus_clock_enable);

  always #50 pclk = ~pclk;

  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic word_t rnd();
    word_t v;
    for (int i = 0; i < 32; i++)
    begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      v[i] = lfsr_q[0];
    end
    return v;
  endfunction

  function automatic word_t merge(word_t old, word_t dat, logic [3:0] s, word_t mask);
    word_t ln;
    ln = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((old & ~ln) | (dat & ln)) & mask;
  endfunction

  // Entered right after a rising edge; the trailing idle cycle keeps two calls from driving one step twice.
  task automatic apb(input logic [11:0] a, input logic w, input word_t dat, input logic [3:0] s,
                     output word_t rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The loop has no timeout of its own; the watchdog ends a hung wait, so a hung slave still reaches the closing verdict.
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic check_all;
    for (int i = 0; i < 3; i++)
    begin
      apb(adr[i], 1'b0, 32'h0, 4'h0, r, e);
      `CHK(r, m[i])
    end
    `CHK(fast_o, m[0])
    `CHK(slow_o, m[1])
    `CHK(system_bus_clock_enable, m[2])
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done;
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    n_errors = 0;
    comparisons = 0;
    lfsr_q = 16'h6e34;
    m = '{`RESET_FAST_RST, `RESET_SLOW_RST, `RESET_CLK_EN};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_all;
    for (int i = 0; i < 32; i++)
    begin
      apb(adr[0], 1'b1, (32'h1 << i) & mk[0], 4'hf, r, e);
      `CHK(fast_o, (32'h1 << i) & mk[0])
      apb(adr[1], 1'b1, (32'h1 << i) & mk[1], 4'hf, r, e);
      `CHK(slow_o, (32'h1 << i) & mk[1])
    end
    // The walk ends on bit 31, which is reserved in both reset registers.
    m[0] = (32'h1 << 31) & mk[0];
    m[1] = (32'h1 << 31) & mk[1];
    for (int k = 0; k < 80; k++)
    begin
      d = rnd();
      x = rnd();
      idx = x[2:0] % 5;
      if (idx < 3)
        d = d & mk[idx];
      apb(adr[idx], x[8], d, x[8] ? x[7:4] : 4'h0, r, e);
      `CHK(e, idx >= 3)
      if (x[8] && idx < 3)
        m[idx] = merge(m[idx], d, x[7:4], mk[idx]);
      if (!x[8])
        `CHK(r, (idx < 3) ? m[idx] : 32'h0)
      `CHK(fast_o, m[0])
      `CHK(slow_o, m[1])
      `CHK(system_bus_clock_enable, m[2])
    end
    check_all;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    m = '{`RESET_FAST_RST, `RESET_SLOW_RST, `RESET_CLK_EN};
    check_all;
    test_done;
  end
endmodule
`default_nettype wire
